/* File: gpio_port_top.sv */
// The address map and the strobed register port were decided locally.
module gpio_port_top
    import gpio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output byte_t o_rdata,
    input wire port_bus_t i_pin_in,
    input wire port_bus_t i_periph_out,
    output port_bus_t o_pin_out,
    output port_bus_t o_pin_oe,
    output port_bus_t o_pull_en
);
    port_bus_t latch_reg;
    port_bus_t dir_reg;
    byte_t pull_reg;
    byte_t segdis_reg;
    byte_t rdata_reg;
    byte_t rdata_next;
    op_t wr_op;
    logic [SEL_W-1:0] sel;
    logic [OFS_W-1:0] ofs;
    logic in_port_win;
    pad_drive_t drive [NUM_PORTS];

    function automatic logic [SEL_W-1:0] port_sel(input logic [ADDR_W-1:0] a);
        port_sel = a[SEL_LSB +: SEL_W];
    endfunction : port_sel

    function automatic logic [OFS_W-1:0] port_ofs(input logic [ADDR_W-1:0] a);
        port_ofs = a[OFS_W-1:0];
    endfunction : port_ofs

    // what the port register shows to a read, bit by bit
    function automatic byte_t port_view(
        input byte_t latch,
        input byte_t dir,
        input byte_t pin,
        input byte_t periph,
        input logic periph_rd
    );
        byte_t out_side;
        out_side = periph_rd ? periph : latch; // [R4]
        port_view = (dir & out_side) | (~dir & pin); // [R1] [R5]
    endfunction : port_view

    function automatic byte_t bit_mask(input byte_t wdata);
        bit_mask = byte_t'(8'h01) << wdata[BIDX_LSB +: BIDX_W];
    endfunction : bit_mask

    // bit operations are internal read-modify-write cycles: unnamed bits
    // take whatever the read returned, so they may change
    function automatic byte_t bit_op(input op_t op, input byte_t view, input byte_t mask);
        case (op)
            OP_BSET: bit_op = view | mask; // [R10] [R11]
            OP_BCLR: bit_op = view & ~mask; // [R10] [R11]
            OP_BTGL: bit_op = view ^ mask; // [R10] [R11]
            default: bit_op = view;
        endcase
    endfunction : bit_op

    assign sel = port_sel(i_addr);
    assign ofs = port_ofs(i_addr);
    assign in_port_win = (i_addr < PORT_WIN_TOP);

    always_comb begin
        wr_op = OP_NONE;
        if (i_wr && in_port_win) begin
            case (ofs)
                OFS_DATA: wr_op = OP_STORE;
                OFS_DIR: wr_op = OP_DIR;
                OFS_BSET: wr_op = OP_BSET;
                OFS_BCLR: wr_op = OP_BCLR;
                OFS_BTGL: wr_op = OP_BTGL;
                default: wr_op = OP_NONE;
            endcase
        end
    end

    // port latches: a store loads the latch in either mode
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch_reg[p] <= LATCH_RST;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (sel == SEL_W'(p)) begin
                    case (wr_op)
                        OP_STORE: latch_reg[p] <= i_wdata; // [R2] [R3]
                        OP_BSET, OP_BCLR, OP_BTGL: begin
                            latch_reg[p] <= bit_op(wr_op,
                                port_view(latch_reg[p], dir_reg[p], i_pin_in[p],
                                    i_periph_out[p], PORT_PERIPH_RD[p]),
                                bit_mask(i_wdata)); // [R10] [R11]
                        end
                        default: latch_reg[p] <= latch_reg[p];
                    endcase
                end
            end
        end
    end

    // direction registers: plain stores only, no bit operations on them
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dir_reg[p] <= DIR_RST; // [R9] [R12]
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_op == OP_DIR && sel == SEL_W'(p)) begin
                    dir_reg[p] <= i_wdata; // [R5] [R12]
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pull_reg <= PULL_RST;
        end else if (i_wr && i_addr == ADDR_PULL) begin
            pull_reg <= i_wdata; // [R8]
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            segdis_reg <= SEGDIS_RST;
        end else if (i_wr && i_addr == ADDR_SEGDIS) begin
            segdis_reg <= i_wdata; // [R8]
        end
    end

    always_comb begin
        rdata_next = READ_ZERO;
        if (i_rd) begin
            if (in_port_win) begin
                case (ofs)
                    OFS_DATA: rdata_next = port_view(latch_reg[sel], dir_reg[sel],
                        i_pin_in[sel], i_periph_out[sel], PORT_PERIPH_RD[sel]); // [R1] [R4]
                    OFS_PINS: rdata_next = i_pin_in[sel];
                    // direction reads as zero; software must not rely on it
                    OFS_DIR: rdata_next = READ_ZERO; // [R7]
                    default: rdata_next = READ_ZERO;
                endcase
            end else if (i_addr == ADDR_PULL) begin
                rdata_next = pull_reg;
            end else if (i_addr == ADDR_SEGDIS) begin
                rdata_next = segdis_reg;
            end
        end
    end

    // read data stand for exactly the one cycle after the strobe
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_pad
        gpio_pad_drive u_pad (
            .i_sys_clk(i_sys_clk),
            .i_sys_rst(i_sys_rst),
            .i_latch(latch_reg[g]),
            .i_dir(dir_reg[g]),
            .i_open_drain(PORT_OD[g]),
            .i_pull_sel(pull_reg[g]),
            .i_seg_disable(segdis_reg[g]),
            .o_drive(drive[g])
        );
        assign o_pin_out[g] = drive[g].out; // [R3]
        assign o_pin_oe[g] = drive[g].oe; // [R6]
        assign o_pull_en[g] = drive[g].pu; // [R8]
    end
endmodule : gpio_port_top

/* File: gpio_pkg.sv */
// Behaviour
// R1 - input-mode bit reads back the sampled pin level.
// R2 - input-mode write loads only the latch; pin stays undriven.
// R3 - output-mode write loads the latch; pin driven from latch.
// R4 - output-mode read returns latch, or peripheral output on peripheral-readback ports.
// R5 - direction register selects input or output for each bit of the port separately.
// R6 - open-drain output with latch one releases the pin (high impedance).
// R7 - direction registers are write-only; reads give no valid value.
// R8 - pull-up only in input mode, gated by pull-up and segment-disable registers.
// R9 - after reset every pin stays input until direction is written.
// R10 - bit operation writes sampled pin level back into unnamed input bits.
// R11 - bit operation writes peripheral output back into unnamed output bits there.
// R12 - direction bit zero is input, one is output; resets to zero.
package gpio_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 2;
    localparam int SEL_LSB = 3;
    localparam int OFS_W = 3;
    localparam int BIDX_W = 3;
    localparam int BIDX_LSB = 0;
    localparam logic [ADDR_W-1:0] PORT_WIN_TOP = 8'h20;
    localparam logic [OFS_W-1:0] OFS_DATA = 3'h0;
    localparam logic [OFS_W-1:0] OFS_DIR = 3'h1;
    localparam logic [OFS_W-1:0] OFS_BSET = 3'h2;
    localparam logic [OFS_W-1:0] OFS_BCLR = 3'h3;
    localparam logic [OFS_W-1:0] OFS_BTGL = 3'h4;
    localparam logic [OFS_W-1:0] OFS_PINS = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_PULL = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_SEGDIS = 8'h21;
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
    localparam logic [PORT_W-1:0] PULL_RST = 8'h00;
    localparam logic [PORT_W-1:0] SEGDIS_RST = 8'h00;
    localparam logic [PORT_W-1:0] READ_ZERO = 8'h00;
    localparam logic [NUM_PORTS-1:0] PORT_OD = 4'h4;
    localparam logic [NUM_PORTS-1:0] PORT_PERIPH_RD = 4'h2;

    typedef logic [PORT_W-1:0] byte_t;
    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bus_t;

    typedef struct packed {
        byte_t out;
        byte_t oe;
        byte_t pu;
    } pad_drive_t;

    typedef enum logic [5:0] {
        OP_NONE = 6'b000001,
        OP_STORE = 6'b000010,
        OP_DIR = 6'b000100,
        OP_BSET = 6'b001000,
        OP_BCLR = 6'b010000,
        OP_BTGL = 6'b100000
    } op_t;
endpackage : gpio_pkg

/* File: gpio_pad_drive.sv */
module gpio_pad_drive
    import gpio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire byte_t i_latch,
    input wire byte_t i_dir,
    input wire logic i_open_drain,
    input wire logic i_pull_sel,
    input wire logic i_seg_disable,
    output pad_drive_t o_drive
);
    pad_drive_t drive_next;

    always_comb begin
        drive_next.out = i_open_drain ? READ_ZERO : i_latch; // [R3]
        // open drain only ever pulls low; a one lets the pin float
        drive_next.oe = i_open_drain ? (i_dir & ~i_latch) : i_dir; // [R6] [R2] [R12]
        drive_next.pu = ~i_dir & {PORT_W{i_pull_sel & i_seg_disable}}; // [R8]
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_drive <= '0; // [R9]
        end else begin
            o_drive <= drive_next;
        end
    end
endmodule : gpio_pad_drive

/* File: gpio_port_assertions.sv */
module gpio_port_assertions
    import gpio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire byte_t o_rdata,
    input wire port_bus_t i_pin_in,
    input wire port_bus_t i_periph_out,
    input wire port_bus_t o_pin_out,
    input wire port_bus_t o_pin_oe,
    input wire port_bus_t o_pull_en
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    property p_rst_in; $fell(i_sys_rst) |-> o_pin_oe == '0 && o_pull_en == '0; endproperty
    a_rst_in: assert property (p_rst_in) else $error("pins active after reset");
    property p_oe; (i_wr && i_addr == 8'h01) |-> ##2 o_pin_oe[0] == $past(i_wdata, 2); endproperty
    a_oe: assert property (p_oe) else $error("port0 enable not from direction");
    property p_out;
        (i_wr && i_addr == 8'h00) |-> ##2 ((o_pin_out[0] ^ $past(i_wdata, 2)) & o_pin_oe[0]) == '0;
    endproperty
    a_out: assert property (p_out) else $error("port0 driven level not latch");
    property p_od; o_pin_out[2] == '0; endproperty
    a_od: assert property (p_od) else $error("open-drain port drives high");
    property p_pull; (o_pull_en & o_pin_oe) == '0; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on a driven pin");
    property p_rd_in;
        (i_rd && i_addr == 8'h00 && o_pin_oe[0] == '0 && !$past(i_wr)) |=> o_rdata == $past(i_pin_in[0]);
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("input read not pin level");
    property p_rd_pe;
        (i_rd && i_addr == 8'h08 && o_pin_oe[1] == 8'hFF && !$past(i_wr))
            |=> o_rdata == $past(i_periph_out[1]);
    endproperty
    a_rd_pe: assert property (p_rd_pe) else $error("port1 read not peripheral");
    property p_dir_rd; (i_rd && i_addr < 8'h20 && i_addr[2:0] == OFS_DIR) |=> o_rdata == '0; endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction read not zero");
    c_bset: cover property (i_wr && i_addr == 8'h02);
    c_rd_pe: cover property (i_rd && o_pin_oe[1] != '0);
    c_pull: cover property (o_pull_en[0] != '0);
endmodule : gpio_port_assertions

/* File: pin_world.sv */
module pin_world
    import gpio_pkg::*;
(
    input wire port_bus_t i_out,
    input wire port_bus_t i_oe,
    input wire port_bus_t i_pu,
    input wire port_bus_t i_ext_val,
    output port_bus_t o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // the outside network is weak: a pin the port leaves alone shows it,
    // unless the internal pull-up is on, which then reads high
    assign o_pin = (i_oe & i_out) | (~i_oe & (i_ext_val | i_pu));
endmodule : pin_world

/* File: gpio_port_test.sv */
module gpio_port_test
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] wa; byte_t wd; logic [7:0] ra; byte_t ex;} row_t;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    byte_t i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    byte_t o_rdata;
    port_bus_t pins, o_pin_out, o_pin_oe, o_pull_en;
    port_bus_t periph = {8'h00, 8'h00, 8'h96, 8'h00};
    int err_total = 0;
    int checked = 0;
    row_t rows [13] = '{'{8'h00, 8'h3C, 8'h00, 8'h5A}, '{8'h01, 8'hFF, 8'h01, 8'h00},
        '{8'h00, 8'hC3, 8'h00, 8'hC3}, '{8'h01, 8'h0F, 8'h00, 8'h53},
        '{8'h09, 8'hFF, 8'h08, 8'h96}, '{8'h02, 8'h07, 8'h00, 8'h53},
        '{8'h01, 8'hFF, 8'h00, 8'hD3}, '{8'h10, 8'hF0, 8'h15, 8'h5A},
        '{8'h11, 8'hFF, 8'h15, 8'h50}, '{8'h0B, 8'h01, 8'h30, 8'h00},
        '{8'h04, 8'h01, 8'h00, 8'hD1}, '{8'h20, 8'h01, 8'h20, 8'h01},
        '{8'h21, 8'h01, 8'h21, 8'h01}};
    always #4 i_sys_clk = ~i_sys_clk;
    gpio_port_top gpio_port_top_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pins),
        .i_periph_out(periph), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_en(o_pull_en));
    pin_world pin_world_i (.i_out(o_pin_out), .i_oe(o_pin_oe),
        .i_pu(o_pull_en), .i_ext_val({4{8'h5A}}), .o_pin(pins));
    task automatic chk(input string what, input byte_t exp, input byte_t got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input byte_t d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        // pads are registered one edge behind the register
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output byte_t v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd
    task automatic conclude;
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #50000;
        err_total++;
        conclude();
    end
    initial begin
        byte_t v;
        repeat (8) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            chk("oe_after_reset", 8'h00, o_pin_oe[p]);
        end
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, v);
            chk("rdata", rows[i].ex, v);
        end
        chk("pin_out1", 8'h94, o_pin_out[1]);
        chk("oe2", 8'h0F, o_pin_oe[2]);
        wr(8'h20, 8'h01);
        wr(8'h21, 8'h01);
        chk("pull0_out", 8'h00, o_pull_en[0]);
        wr(8'h01, 8'h00);
        chk("pull0_in", 8'hFF, o_pull_en[0]);
        // second reset in mid-run: pads, pull-ups and latches must all fall back
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            chk("oe_rerun", 8'h00, o_pin_oe[p]);
            chk("pull_rerun", 8'h00, o_pull_en[p]);
        end
        rd(8'h00, v);
        chk("view_rerun", 8'h5A, v);
        wr(8'h01, 8'hFF);
        rd(8'h00, v);
        chk("latch_rerun", 8'h00, v);
        conclude();
    end
endmodule : gpio_port_test
bind gpio_port_top gpio_port_assertions gpio_port_assertions_i (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_pin_in(i_pin_in), .i_periph_out(i_periph_out),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_en(o_pull_en));
